// ===== qenc_cfg.svh
// Purpose: offsets, field positions, codes and reset values of the encoder block
// Assumes: 32-bit apb data, one aligned word per register
// Notes: definitions only
`ifndef QENC_CFG_SVH
`define QENC_CFG_SVH

// ==========================================================================
// register byte addresses
`define QE_OFF_CTRL 8'h00
`define QE_OFF_IOCL 8'h04
`define QE_OFF_IOCH 8'h08
`define QE_OFF_STAT 8'h0C
`define QE_OFF_POS 8'h10
`define QE_OFF_GEC 8'h14
`define QE_OFF_LEC 8'h18
`define QE_OFF_INIT 8'h1C
`define QE_OFF_CAP 8'h20

// ==========================================================================
// writable masks and reset values
`define QE_CTRL_WMASK 16'hBF7F
`define QE_IOCL_WMASK 16'hFFF0
`define QE_IOCH_WMASK 16'h0001
`define QE_STAT_WMASK 16'h1400
`define QE_RST16 16'h0000
`define QE_RST32 32'h0000_0000

// ==========================================================================
// control fields
`define QE_ON 15
`define QE_IDLE 13
`define QE_POS_INIT_SELECT 12:10
`define QE_IMV 9:8
`define QE_IMV_B 9
`define QE_IMV_A 8
`define QE_TIMER_PRESCALE_SEL 6:4
`define QE_DIRECTION_INVERT 3
`define QE_GATE_CONTROL_ON 2
`define QE_CCM 1:0
`define QE_CCM_GATED 1
// io control fields
`define QE_QCAP 15
`define QE_FLTR 14
`define QE_FILTER_CLOCK_DIV 13:11
`define QE_OUTF 10:9
`define QE_SWAP 8
`define QE_POL 7:4
`define QE_POL_HOME 7
`define QE_POL_IDX 6
`define QE_POL_B 5
`define QE_POL_A 4
`define QE_HCAP 0
// status fields
`define QE_GE_FLAG 13
`define QE_GE_EN 12
`define QE_LE_FLAG 11
`define QE_LE_EN 10

// ==========================================================================
// codes
`define QE_PI_NONE 3'h0
`define QE_PI_RESET 3'h1
`define QE_PI_NEXT 3'h2
`define QE_PI_HOME1 3'h3
`define QE_PI_HOME2 3'h4
`define QE_PI_GEC 3'h5
`define QE_PI_MODIDX 3'h7
`define QE_PI_MOD 3'h6
`define QE_CCM_QUAD 2'h0
`define QE_CCM_UPDN 2'h1
`define QE_CCM_EXTG 2'h2
`define QE_CCM_TMR 2'h3
`define QE_OUT_OFF 2'h0
`define QE_OUT_GE 2'h1
`define QE_OUT_LE 2'h2
`define QE_OUT_ANY 2'h3

`endif

// ===== qenc_pkg.sv
// Purpose: shared types and helpers of the encoder block
// Assumes: nothing
// Notes: divider tick helper used by timer and filter prescalers
package qenc_pkg;
	typedef logic [31:0] word_t;
	typedef enum logic [1:0] {INIT_IDLE, INIT_WAIT_HOME, INIT_WAIT_IDX2, INIT_WAIT_IDX1} init_st_e;

	// tick when low sel bits of a free counter are all zero: 1:2^sel
	function automatic logic div_tick(input logic [6:0] cnt, input logic [2:0] sel);
		logic [7:0] mask;
		mask = (8'h01 << sel) - 8'h01;
		return ((cnt & mask[6:0]) == 7'h00);
	endfunction
endpackage

// ===== qenc_filter.sv
// Purpose: digital noise filter for the four encoder inputs
// Assumes: inputs synchronous to pclk
// Notes: change accepted after three equal divided-clock samples
`timescale 1ns/100ps
`default_nettype none
`include "qenc_cfg.svh"
module qenc_filter (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic [3:0] raw,
	input wire logic filter_on,
	input wire logic [2:0] div_sel,
	output logic [3:0] clean
);
	logic [6:0] div_q;
	logic [2:0] hist_q [4];
	logic [3:0] clean_q;
	logic tick;

	// ==================================================================
	// free running filter clock divider
	assign tick = qenc_pkg::div_tick(div_q, div_sel);
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			div_q <= 7'h00;
		end else begin
			div_q <= div_q + 7'h01;
		end
	end

	// ==================================================================
	// sample history and acceptance
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			for (int i = 0; i < 4; i++) begin
				hist_q[i] <= 3'h0;
			end
			clean_q <= 4'h0;
		end else begin
			for (int i = 0; i < 4; i++) begin
				if (!filter_on) begin
					clean_q[i] <= raw[i];
				end else if (tick) begin
					hist_q[i] <= {hist_q[i][1:0], raw[i]};
					if ({hist_q[i][1:0], raw[i]} == 3'h7) begin
						clean_q[i] <= 1'b1;
					end else if ({hist_q[i][1:0], raw[i]} == 3'h0) begin
						clean_q[i] <= 1'b0;
					end
				end
			end
		end
	end
	assign clean = clean_q;
endmodule // qenc_filter
`default_nettype wire

// ===== qenc_decoder.sv
// Purpose: quadrature state change decoder
// Assumes: a and b already conditioned
// Notes: up and down are single-cycle, never both
`timescale 1ns/100ps
`default_nettype none
module qenc_decoder (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic a,
	input wire logic b,
	output logic up,
	output logic down
);
	logic a_q;
	logic b_q;

	// ==================================================================
	// previous state
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			a_q <= 1'b0;
			b_q <= 1'b0;
		end else begin
			a_q <= a;
			b_q <= b;
		end
	end

	// one phase changed: direction from order; both changed gives neither
	assign up = (a == ~b_q) && (b == a_q);
	assign down = (a == b_q) && (b == ~a_q);
endmodule // qenc_decoder
`default_nettype wire

// ===== quadrature_encoder_control.sv
// Purpose: control, conditioning, position and compare logic of an encoder interface
// Assumes: apb slave, pins synchronous to pclk
// Notes: answer lands in the second access cycle
`timescale 1ns/100ps
`default_nettype none
`include "qenc_cfg.svh"
module quadrature_encoder_control (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic pready,
	output logic [31:0] prdata,
	output logic pslverr,
	input wire logic phase_a_in,
	input wire logic phase_b_in,
	input wire logic index_in,
	input wire logic home_in,
	input wire logic idle_mode,
	output logic compare_out_pin
);
	logic pready_q;
	logic [31:0] prdata_q;
	logic pslverr_q;
	logic [15:0] ctrl_q;
	logic [15:0] iocl_q;
	logic [15:0] ioch_q;
	logic [15:0] stat_q;
	qenc_pkg::word_t pos_q;
	qenc_pkg::word_t pos_d;
	qenc_pkg::word_t gec_q;
	qenc_pkg::word_t lec_q;
	qenc_pkg::word_t init_q;
	qenc_pkg::word_t cap_q;
	qenc_pkg::init_st_e init_st_q;
	logic [6:0] tdiv_q;
	logic match_q;
	logic home_q;
	logic a_prev_q;
	logic cmp_q;
	logic [3:0] clean;
	logic a_c;
	logic b_c;
	logic idx_c;
	logic home_c;
	logic q_up;
	logic q_dn;
	logic run;
	logic wr;
	logic rd_setup;
	logic idx_evt;
	logic home_evt;
	logic step;
	logic up;
	logic gate_ok;
	logic pos_ge;
	logic pos_le;
	logic init_load;
	logic [2:0] pos_init_select;

	// ==================================================================
	// input conditioning: filter, swap, polarity
	qenc_filter u_filter (
		.pclk(pclk),
		.presetn(presetn),
		.raw({home_in, index_in, phase_b_in, phase_a_in}),
		.filter_on(iocl_q[`QE_FLTR]),
		.div_sel(iocl_q[`QE_FILTER_CLOCK_DIV]),
		.clean(clean)
	);
	assign a_c = (iocl_q[`QE_SWAP] ? clean[1] : clean[0]) ^ iocl_q[`QE_POL_A];
	assign b_c = (iocl_q[`QE_SWAP] ? clean[0] : clean[1]) ^ iocl_q[`QE_POL_B];
	assign idx_c = clean[2] ^ iocl_q[`QE_POL_IDX];
	assign home_c = clean[3] ^ iocl_q[`QE_POL_HOME];

	qenc_decoder u_decoder (
		.pclk(pclk),
		.presetn(presetn),
		.a(a_c),
		.b(b_c),
		.up(q_up),
		.down(q_dn)
	);

	// ==================================================================
	// run state and events
	assign run = ctrl_q[`QE_ON] && !(ctrl_q[`QE_IDLE] && idle_mode);
	assign pos_init_select = ctrl_q[`QE_POS_INIT_SELECT];
	// index match: index high with phases at the chosen levels
	assign idx_evt = run && idx_c && !match_q && (b_c == ctrl_q[`QE_IMV_B])
		&& (a_c == ctrl_q[`QE_IMV_A]);
	assign home_evt = run && home_c && !home_q;
	assign pos_ge = $signed(pos_q) >= $signed(gec_q);
	assign pos_le = $signed(pos_q) <= $signed(lec_q);
	assign wr = psel && penable && pready_q && pwrite;
	assign rd_setup = psel && penable && !pready_q;

	// edge detect history
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			match_q <= 1'b0;
			home_q <= 1'b0;
			a_prev_q <= 1'b0;
		end else begin
			match_q <= idx_c && (b_c == ctrl_q[`QE_IMV_B]) && (a_c == ctrl_q[`QE_IMV_A]);
			home_q <= home_c;
			a_prev_q <= a_c;
		end
	end

	// internal timer prescaler, runs only while operating
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			tdiv_q <= 7'h00;
		end else if (run) begin
			tdiv_q <= tdiv_q + 7'h01;
		end
	end

	// ==================================================================
	// count source, direction and gating
	assign gate_ok = !(ctrl_q[`QE_GATE_CONTROL_ON] || ctrl_q[`QE_CCM_GATED]) || b_c;
	always_comb begin
		step = 1'b0;
		up = !ctrl_q[`QE_DIRECTION_INVERT];
		case (ctrl_q[`QE_CCM])
			`QE_CCM_QUAD: begin
				step = q_up || q_dn;
				up = q_up ^ ctrl_q[`QE_DIRECTION_INVERT];
			end
			`QE_CCM_UPDN: begin
				step = a_c && !a_prev_q;
				up = b_c;
			end
			`QE_CCM_EXTG: begin
				step = a_c && !a_prev_q;
			end
			`QE_CCM_TMR: begin
				step = qenc_pkg::div_tick(tdiv_q, ctrl_q[`QE_TIMER_PRESCALE_SEL]);
			end
			default: begin
				step = 1'b0;
			end
		endcase
		if (!run || !gate_ok) begin
			step = 1'b0;
		end
	end

	// ==================================================================
	// homing and next-index initialization sequence
	assign init_load = idx_evt && (init_st_q == qenc_pkg::INIT_WAIT_IDX1);
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			init_st_q <= qenc_pkg::INIT_IDLE;
		end else if (wr && paddr == `QE_OFF_CTRL) begin
			case (pwdata[`QE_POS_INIT_SELECT])
				`QE_PI_NEXT: init_st_q <= qenc_pkg::INIT_WAIT_IDX1;
				`QE_PI_HOME1, `QE_PI_HOME2: init_st_q <= qenc_pkg::INIT_WAIT_HOME;
				default: init_st_q <= qenc_pkg::INIT_IDLE;
			endcase
		end else begin
			case (init_st_q)
				qenc_pkg::INIT_WAIT_HOME: begin
					if (home_evt) begin
						init_st_q <= (pos_init_select == `QE_PI_HOME1) ? qenc_pkg::INIT_WAIT_IDX1
							: qenc_pkg::INIT_WAIT_IDX2;
					end
				end
				qenc_pkg::INIT_WAIT_IDX2: begin
					if (idx_evt) begin
						init_st_q <= qenc_pkg::INIT_WAIT_IDX1;
					end
				end
				qenc_pkg::INIT_WAIT_IDX1: begin
					if (idx_evt) begin
						init_st_q <= qenc_pkg::INIT_IDLE;
					end
				end
				default: init_st_q <= qenc_pkg::INIT_IDLE;
			endcase
		end
	end

	// ==================================================================
	// position counter next value
	always_comb begin
		pos_d = pos_q;
		if (wr && paddr == `QE_OFF_POS) begin
			pos_d = pwdata;
		end else if (run && pos_init_select == `QE_PI_GEC && pos_q == gec_q) begin
			pos_d = `QE_RST32;
		end else if (idx_evt && (pos_init_select == `QE_PI_RESET || pos_init_select == `QE_PI_MODIDX)) begin
			pos_d = `QE_RST32;
		end else if (init_load) begin
			pos_d = init_q;
		end else if (step) begin
			if (pos_init_select >= `QE_PI_MOD && up && pos_q == gec_q) begin
				pos_d = lec_q;
			end else if (pos_init_select >= `QE_PI_MOD && !up && pos_q == lec_q) begin
				pos_d = gec_q;
			end else begin
				pos_d = up ? pos_q + 32'h0000_0001 : pos_q - 32'h0000_0001;
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pos_q <= `QE_RST32;
		end else begin
			pos_q <= pos_d;
		end
	end

	// position capture on index match or home edge
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cap_q <= `QE_RST32;
		end else if ((idx_evt && iocl_q[`QE_QCAP]) || (home_evt && ioch_q[`QE_HCAP])) begin
			cap_q <= pos_q;
		end
	end

	// ==================================================================
	// control and data registers
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl_q <= `QE_RST16;
			iocl_q <= `QE_RST16;
			ioch_q <= `QE_RST16;
			gec_q <= `QE_RST32;
			lec_q <= `QE_RST32;
			init_q <= `QE_RST32;
		end else if (wr) begin
			case (paddr)
				`QE_OFF_CTRL: ctrl_q <= pwdata[15:0] & `QE_CTRL_WMASK;
				`QE_OFF_IOCL: iocl_q <= pwdata[15:0] & `QE_IOCL_WMASK;
				`QE_OFF_IOCH: ioch_q <= pwdata[15:0] & `QE_IOCH_WMASK;
				`QE_OFF_GEC: gec_q <= pwdata;
				`QE_OFF_LEC: lec_q <= pwdata;
				`QE_OFF_INIT: init_q <= pwdata;
				default: ;
			endcase
		end
	end

	// compare flags: hardware set wins over write-one clear
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			stat_q <= `QE_RST16;
		end else begin
			stat_q[`QE_GE_FLAG] <= pos_ge || (stat_q[`QE_GE_FLAG]
				&& !(wr && paddr == `QE_OFF_STAT && pwdata[`QE_GE_FLAG]));
			stat_q[`QE_LE_FLAG] <= pos_le || (stat_q[`QE_LE_FLAG]
				&& !(wr && paddr == `QE_OFF_STAT && pwdata[`QE_LE_FLAG]));
			if (wr && paddr == `QE_OFF_STAT) begin
				stat_q[`QE_GE_EN] <= pwdata[`QE_GE_EN];
				stat_q[`QE_LE_EN] <= pwdata[`QE_LE_EN];
			end
		end
	end

	// ==================================================================
	// compare output pin
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cmp_q <= 1'b0;
		end else begin
			case (iocl_q[`QE_OUTF])
				`QE_OUT_GE: cmp_q <= ctrl_q[`QE_ON] && pos_ge;
				`QE_OUT_LE: cmp_q <= ctrl_q[`QE_ON] && pos_le;
				`QE_OUT_ANY: cmp_q <= ctrl_q[`QE_ON] && (pos_ge || pos_le);
				default: cmp_q <= 1'b0;
			endcase
		end
	end
	assign compare_out_pin = cmp_q;

	// ==================================================================
	// apb slave: pready in the second access cycle
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready_q <= 1'b0;
			prdata_q <= `QE_RST32;
			pslverr_q <= 1'b0;
		end else begin
			pready_q <= rd_setup;
			pslverr_q <= 1'b0;
			prdata_q <= `QE_RST32;
			if (rd_setup) begin
				case (paddr)
					`QE_OFF_CTRL: prdata_q <= {16'h0000, ctrl_q};
					`QE_OFF_IOCL: prdata_q <= {16'h0000, iocl_q[15:4], home_c, idx_c, b_c, a_c};
					`QE_OFF_IOCH: prdata_q <= {16'h0000, ioch_q};
					`QE_OFF_STAT: prdata_q <= {16'h0000, stat_q};
					`QE_OFF_POS: prdata_q <= pos_q;
					`QE_OFF_GEC: prdata_q <= gec_q;
					`QE_OFF_LEC: prdata_q <= lec_q;
					`QE_OFF_INIT: prdata_q <= init_q;
					`QE_OFF_CAP: prdata_q <= cap_q;
					default: pslverr_q <= 1'b1;
				endcase
			end
		end
	end
	assign pready = pready_q;
	assign prdata = prdata_q;
	assign pslverr = pslverr_q;

	// ==================================================================
	// assertions
	sequence s_pos_wr;
		wr && paddr == `QE_OFF_POS;
	endsequence
	sequence s_stat_ge_clr;
		wr && paddr == `QE_OFF_STAT && pwdata[`QE_GE_FLAG];
	endsequence

	property p_off_hold;
		@(posedge pclk) disable iff (!presetn)
		!ctrl_q[`QE_ON] && !(wr && paddr == `QE_OFF_POS) |=> $stable(pos_q);
	endproperty
	a_off_hold: assert property (p_off_hold) else $error("position moved while off");

	property p_pos_load;
		@(posedge pclk) disable iff (!presetn)
		s_pos_wr |=> pos_q == $past(pwdata);
	endproperty
	a_pos_load: assert property (p_pos_load) else $error("position write lost");

	property p_idle_hold;
		@(posedge pclk) disable iff (!presetn)
		ctrl_q[`QE_IDLE] && idle_mode && !(wr && paddr == `QE_OFF_POS) |=> pos_q == $past(pos_q);
	endproperty
	a_idle_hold: assert property (p_idle_hold) else $error("position moved in idle");

	property p_idx_reset;
		@(posedge pclk) disable iff (!presetn)
		idx_evt && pos_init_select == `QE_PI_RESET && !(wr && paddr == `QE_OFF_POS) |=> pos_q == 32'h0;
	endproperty
	a_idx_reset: assert property (p_idx_reset) else $error("index did not reset position");

	property p_gec_reset;
		@(posedge pclk) disable iff (!presetn)
		run && pos_init_select == `QE_PI_GEC && pos_q == gec_q && !(wr && paddr == `QE_OFF_POS)
			|=> pos_q == 32'h0;
	endproperty
	a_gec_reset: assert property (p_gec_reset) else $error("no reset at high compare");

	property p_idx_cap;
		@(posedge pclk) disable iff (!presetn)
		idx_evt && iocl_q[`QE_QCAP] |=> cap_q == $past(pos_q);
	endproperty
	a_idx_cap: assert property (p_idx_cap) else $error("index capture missed");

	property p_ge_flag;
		@(posedge pclk) disable iff (!presetn)
		pos_ge |=> stat_q[`QE_GE_FLAG];
	endproperty
	a_ge_flag: assert property (p_ge_flag) else $error("high compare flag not set");

	property p_le_flag;
		@(posedge pclk) disable iff (!presetn)
		pos_le |=> stat_q[`QE_LE_FLAG];
	endproperty
	a_le_flag: assert property (p_le_flag) else $error("low compare flag not set");

	property p_ge_sticky;
		@(posedge pclk) disable iff (!presetn)
		stat_q[`QE_GE_FLAG] && !(wr && paddr == `QE_OFF_STAT && pwdata[`QE_GE_FLAG])
			|=> stat_q[`QE_GE_FLAG];
	endproperty
	a_ge_sticky: assert property (p_ge_sticky) else $error("flag cleared without write");

	property p_ge_clear;
		@(posedge pclk) disable iff (!presetn)
		s_stat_ge_clr ##0 !pos_ge |=> !stat_q[`QE_GE_FLAG];
	endproperty
	a_ge_clear: assert property (p_ge_clear) else $error("high compare flag not cleared");

	property p_cmp_off;
		@(posedge pclk) disable iff (!presetn)
		(iocl_q[`QE_OUTF] == `QE_OUT_OFF || !ctrl_q[`QE_ON]) ##1 1'b1 |-> !compare_out_pin;
	endproperty
	a_cmp_off: assert property (p_cmp_off) else $error("compare pin high while off");
endmodule // quadrature_encoder_control
`default_nettype wire

// ===== enc_model.sv
// Purpose: incremental encoder model with index and home outputs
// Assumes: pins change just after a rising pclk edge
// Notes: a step of two positions breaks the gray order on purpose
`timescale 1ns/100ps
`default_nettype none
module enc_model (
	input wire logic pclk,
	output logic a,
	output logic b,
	output logic idx,
	output logic home
);
	// ========
	// gray position: forward means a leads b
	int s = 0;

	// all pins low at start
	initial begin
		a = 1'b0;
		b = 1'b0;
		idx = 1'b0;
		home = 1'b0;
	end

	// n moves of d positions, each held for hold+1 cycles
	task automatic go(input int d, input int n, input int hold);
		repeat (n) begin
			s = (s + d) & 3;
			@(posedge pclk);
			a <= (s == 1) || (s == 2);
			b <= s[1];
			repeat (hold) @(posedge pclk);
		end
	endtask

	// pulse of n cycles on a (w 0), index (w 1) or home (w 2)
	task automatic blip(input int w, input int n);
		repeat (2) begin
			@(posedge pclk);
			if (w == 0) a <= !a;
			else if (w == 1) idx <= !idx;
			else home <= !home;
			repeat (n - 1) @(posedge pclk);
		end
		repeat (8) @(posedge pclk);
	endtask
endmodule // enc_model
`default_nettype wire

// ===== quadrature_encoder_control_bench.sv
// Purpose: register level bench of the encoder block
// Assumes: encoder pins come from enc_model
// Notes: each chk read waits three cycles so pin effects settle
`timescale 1ns/100ps
`default_nettype none
`include "qenc_cfg.svh"
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin failures++; \
	$display("BAD %0t got %h exp %h", $time, g, e); end end
module quadrature_encoder_control_bench;
	// ========
	// clock, reset and wiring
	logic pclk = 1'b0;
	logic presetn = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic idle_mode = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0000_0000;
	logic [31:0] prdata, rd;
	logic pready, pslverr, err, pin, a, b, idx, home;
	int failures = 0;
	int n_tests = 0;
	int cyc = 0;
	always #2 pclk = ~pclk;
	quadrature_encoder_control dut_u (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.pready(pready), .prdata(prdata), .pslverr(pslverr), .phase_a_in(a),
		.phase_b_in(b), .index_in(idx), .home_in(home), .idle_mode(idle_mode),
		.compare_out_pin(pin));
	enc_model enc_u (.pclk(pclk), .a(a), .b(b), .idx(idx), .home(home));

	// ========
	// verdict
	task automatic end_sim;
		$display("tests %0d failures %0d", n_tests, failures);
		if (failures == 0 && n_tests > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask

	// cycle ceiling against hangs
	always @(posedge pclk) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			failures++;
			end_sim;
		end
	end

	// ========
	// apb transfer: setup, access until pready
	task automatic xfer(input logic w, input logic [7:0] ad, input logic [31:0] wd);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= ad;
		pwdata <= wd;
		@(posedge pclk);
		penable <= 1'b1;
		// wait for the answer; only the cycle ceiling ends a hang
		do begin
			@(posedge pclk);
		end while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic wr(input logic [7:0] ad, input logic [31:0] d);
		xfer(1'b1, ad, d);
	endtask

	task automatic chk(input logic [7:0] ad, input logic [31:0] e);
		repeat (3) @(posedge pclk);
		xfer(1'b0, ad, 32'h0000_0000);
		`CHK(rd, e)
	endtask

	// short forms for the busy registers
	task automatic wctl(input logic [31:0] d);
		wr(`QE_OFF_CTRL, d);
	endtask
	task automatic wio(input logic [31:0] d);
		wr(`QE_OFF_IOCL, d);
	endtask
	task automatic wpos(input logic [31:0] d);
		wr(`QE_OFF_POS, d);
	endtask
	task automatic cpos(input logic [31:0] e);
		chk(`QE_OFF_POS, e);
	endtask

	// ========
	// main sequence
	initial begin
		repeat (20) @(posedge pclk);
		presetn <= 1'b1;
		for (int i = 0; i < 9; i++) if (i != 3) chk(8'(4 * i), 32'h0000_0000);
		chk(`QE_OFF_STAT, 32'h0000_2800);
		xfer(1'b0, 8'h24, 32'h0000_0000);
		`CHK({err, rd}, {1'b1, 32'h0000_0000})
		// module off: registers live, counting frozen
		wctl(32'h0000_FFFF);
		chk(`QE_OFF_CTRL, 32'h0000_BF7F);
		wctl(32'h0000_0000);
		wr(`QE_OFF_GEC, 32'h0000_0005);
		chk(`QE_OFF_GEC, 32'h0000_0005);
		wpos(32'h0000_0000);
		enc_u.go(1, 2, 6);
		cpos(32'h0000_0000);
		// counting both ways, double change ignored, 32-bit wrap
		wctl(32'h0000_8000);
		enc_u.go(1, 3, 6);
		enc_u.go(-1, 1, 6);
		cpos(32'h0000_0002);
		enc_u.go(2, 2, 6);
		cpos(32'h0000_0002);
		wpos(32'h0000_0000);
		enc_u.go(-1, 1, 6);
		cpos(32'hFFFF_FFFF);
		// swap and direction invert reverse the count
		wio(32'h0000_0100);
		wpos(32'h0000_0000);
		enc_u.go(1, 2, 6);
		cpos(32'hFFFF_FFFE);
		wio(32'h0000_0000);
		wctl(32'h0000_8008);
		wpos(32'h0000_0000);
		enc_u.go(1, 2, 6);
		cpos(32'hFFFF_FFFE);
		// conditioned levels with a=0 b=1 index=0 home=0
		wio(32'h0000_00F0);
		chk(`QE_OFF_IOCL, 32'h0000_00FD);
		wio(32'h0000_0100);
		chk(`QE_OFF_IOCL, 32'h0000_0101);
		wio(32'h0000_0000);
		chk(`QE_OFF_IOCL, 32'h0000_0002);
		// index reset needs the phase match
		wctl(32'h0000_8400);
		wpos(32'h0000_0007);
		enc_u.blip(1, 3);
		cpos(32'h0000_0007);
		wctl(32'h0000_8600);
		enc_u.blip(1, 3);
		cpos(32'h0000_0000);
		// next index loads once
		wr(`QE_OFF_INIT, 32'h0000_0055);
		wctl(32'h0000_8A00);
		enc_u.blip(1, 3);
		cpos(32'h0000_0055);
		wpos(32'h0000_0009);
		enc_u.blip(1, 3);
		cpos(32'h0000_0009);
		// first and second index after home, then QE_PI_MODIDX index reset
		wr(`QE_OFF_INIT, 32'h0000_0066);
		wctl(32'h0000_8E00);
		wpos(32'h0000_0001);
		enc_u.blip(1, 3);
		cpos(32'h0000_0001);
		enc_u.blip(2, 3);
		enc_u.blip(1, 3);
		cpos(32'h0000_0066);
		wctl(32'h0000_9200);
		wpos(32'h0000_0001);
		enc_u.blip(2, 3);
		enc_u.blip(1, 3);
		cpos(32'h0000_0001);
		enc_u.blip(1, 3);
		cpos(32'h0000_0066);
		wctl(32'h0000_9E00);
		wpos(32'h0000_0003);
		enc_u.blip(1, 3);
		cpos(32'h0000_0000);
		// capture on index and on home
		wctl(32'h0000_8200);
		wio(32'h0000_8000);
		wpos(32'h0000_0033);
		enc_u.blip(1, 3);
		chk(`QE_OFF_CAP, 32'h0000_0033);
		wio(32'h0000_0000);
		wr(`QE_OFF_IOCH, 32'h0000_0001);
		wpos(32'h0000_0044);
		enc_u.blip(2, 3);
		chk(`QE_OFF_CAP, 32'h0000_0044);
		wr(`QE_OFF_IOCH, 32'h0000_0000);
		// reset at high compare, then modulo wrap
		wctl(32'h0000_9600);
		wpos(32'h0000_0003);
		enc_u.go(1, 2, 6);
		cpos(32'h0000_0000);
		wctl(32'h0000_9800);
		wpos(32'h0000_0005);
		enc_u.go(1, 1, 6);
		cpos(32'h0000_0000);
		// compare flags, clear by writing one
		wctl(32'h0000_8000);
		wr(`QE_OFF_GEC, 32'h0000_0003);
		wr(`QE_OFF_LEC, 32'hFFFF_FFFF);
		wpos(32'h0000_0003);
		wr(`QE_OFF_STAT, 32'h0000_2800);
		chk(`QE_OFF_STAT, 32'h0000_2000);
		wpos(32'h0000_0002);
		wr(`QE_OFF_STAT, 32'h0000_2000);
		chk(`QE_OFF_STAT, 32'h0000_0000);
		wpos(32'hFFFF_FFFF);
		chk(`QE_OFF_STAT, 32'h0000_0800);
		wr(`QE_OFF_STAT, 32'h0000_1400);
		chk(`QE_OFF_STAT, 32'h0000_1C00);
		// output select for each code, at low and at high
		for (int p = 0; p < 2; p++) begin
			wpos(p ? 32'h0000_0003 : 32'hFFFF_FFFF);
			for (int i = 0; i < 4; i++) begin
				wio(32'(i) << 9);
				repeat (4) @(posedge pclk);
				`CHK(pin, p ? i[0] : i[1])
			end
		end
		wctl(32'h0000_0000);
		repeat (4) @(posedge pclk);
		`CHK(pin, 1'b0)
		// idle halt
		wctl(32'h0000_A000);
		idle_mode <= 1'b1;
		wpos(32'h0000_0000);
		enc_u.go(1, 2, 6);
		cpos(32'h0000_0000);
		wctl(32'h0000_8000);
		enc_u.go(1, 1, 6);
		cpos(32'h0000_0001);
		idle_mode <= 1'b0;
		// external clock modes: phase a rise clocks, phase b steers or gates
		wctl(32'h0000_8001);
		wpos(32'h0000_0005);
		enc_u.blip(0, 3);
		cpos(32'h0000_0004);
		wctl(32'h0000_8002);
		enc_u.blip(0, 3);
		cpos(32'h0000_0004);
		enc_u.go(1, 1, 6);
		enc_u.blip(0, 3);
		cpos(32'h0000_0005);
		// filter: short pulses rejected, three samples accepted, divider stretches
		wio(32'h0000_4000);
		wctl(32'h0000_8700);
		wpos(32'h0000_0005);
		enc_u.blip(0, 1);
		enc_u.blip(1, 2);
		cpos(32'h0000_0005);
		enc_u.blip(1, 3);
		cpos(32'h0000_0000);
		wctl(32'h0000_8000);
		enc_u.go(1, 1, 8);
		cpos(32'h0000_0001);
		wio(32'h0000_7800);
		enc_u.go(1, 1, 8);
		cpos(32'h0000_0001);
		repeat (400) @(posedge pclk);
		cpos(32'h0000_0002);
		wio(32'h0000_4800);
		enc_u.go(1, 1, 8);
		cpos(32'h0000_0003);
		end_sim;
	end
endmodule // quadrature_encoder_control_bench
`default_nettype wire
